// >>> shared/mcast_pkg.sv
// shared constants and types for the multicast group tracker
package mcast_pkg;
   // ------------------------------------------------------------
   // sizes and limits
   // ------------------------------------------------------------
   localparam int NPORT = 26;
   localparam int NVLAN = 256;
   localparam int NGRP = 128;
   localparam logic [7:0] VLAN_ADMIT_MAX = 8'h80;
   localparam logic [5:0] GMRP_STATIC_MAX = 6'h20;
   localparam logic [6:0] GMRP_DYN_MAX = 7'h40;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam longint CLK_PERIOD_NS = 20;
   localparam longint SEC_NS = 1000000000;
   localparam int TICK_CYCLES = int'(SEC_NS / CLK_PERIOD_NS);
   localparam logic [15:0] FIRST_QUERY_S = 16'h00FF;
   localparam logic [15:0] QINT_RST = 16'h007D;
   localparam logic [7:0] RLIM_RST = 8'h0A;
   localparam logic [1:0] LEAVE_WAIT_S = 2'h1;
   // one extra tick so that the wait is never shorter than a second
   localparam logic [1:0] LEAVE_TICKS = LEAVE_WAIT_S + 2'h1;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] QINT_OFS = 8'h04;
   localparam logic [7:0] RLIM_OFS = 8'h08;
   localparam logic [7:0] VIDX_OFS = 8'h0C;
   localparam logic [7:0] VCFG_OFS = 8'h10;
   localparam logic [7:0] GPORT_OFS = 8'h14;
   localparam logic [7:0] STAT_OFS = 8'h18;
   localparam int CTRL_SNOOP = 0;
   localparam int CTRL_QOPT = 1;
   localparam int CTRL_GMRP = 2;
   localparam int STAT_OVF = 8;
   localparam int STAT_SCHED = 9;
   localparam int STAT_ADMIT = 11;
   localparam int STAT_GMST = 19;
   localparam int STAT_GMDY = 25;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {QM_NONE, QM_V1, QM_V2} qmode_t;
   typedef enum logic [1:0] {
      SCH_IDLE, SCH_FIRST, SCH_STARTUP, SCH_PERIODIC
   } sched_t;
   typedef struct packed {
      qmode_t ipqm;
      logic ipif;
      logic ver2;
      qmode_t qmode;
      logic vflag;
   } vcfg_t;
   localparam vcfg_t VCFG_RST = '{ipqm: QM_NONE, ipif: 1'b0, ver2: 1'b1,
                                  qmode: QM_NONE, vflag: 1'b1};
   typedef struct packed {
      logic v1seen;
      logic lost;
      logic admit;
   } vst_t;
   typedef struct packed {
      logic valid;
      logic [7:0] vlan;
      logic [27:0] group;
      logic [NPORT-1:0] members;
      logic [NPORT-1:0] unconf;
      logic [NPORT-1:0] leave;
      logic [1:0] lcnt;
   } grp_ent_t;
   typedef struct packed {
      logic query;
      logic report;
      logic leave;
      logic v1;
      logic lower;
      logic [7:0] vlan;
      logic [27:0] group;
      logic [4:0] port;
   } igmp_ev_t;
   typedef struct packed {
      logic valid;
      logic [7:0] vlan;
      logic [27:0] group;
   } lookup_t;
   typedef struct packed {
      logic valid;
      logic flood;
      logic [NPORT-1:0] mask;
   } fwd_t;
   typedef struct packed {
      logic go;
      logic [7:0] vlan;
      logic [27:0] group;
   } gsq_t;
   typedef struct packed {
      logic add;
      logic del;
      logic is_static;
   } gmrp_req_t;
endpackage

// >>> hw/igmp_snoop_querier.sv
// multicast group tracking, querier election and query schedule
module igmp_snoop_querier #(
   parameter int TICK_CYCLES = mcast_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // parsed igmp events, forwarding lookups and gmrp requests
   input wire mcast_pkg::igmp_ev_t ev,
   input wire mcast_pkg::lookup_t lk,
   input wire mcast_pkg::gmrp_req_t gm,
   // query requests and results
   output logic query_go,
   output logic [mcast_pkg::NVLAN-1:0] querier_act,
   output logic [mcast_pkg::NVLAN-1:0] querier_ver2,
   output mcast_pkg::gsq_t gsq,
   output mcast_pkg::fwd_t fwd,
   output logic [mcast_pkg::NPORT-1:0] gmrp_port_en,
   output logic gmrp_ok
);
   typedef struct packed {
      mcast_pkg::vcfg_t [mcast_pkg::NVLAN-1:0] vcfg;
      mcast_pkg::vst_t [mcast_pkg::NVLAN-1:0] vst;
      mcast_pkg::grp_ent_t [mcast_pkg::NGRP-1:0] grp;
      logic snoop;
      logic qopt;
      logic gmrp;
      logic [15:0] qint;
      logic [7:0] rlim;
      logic [7:0] vidx;
      logic [7:0] admit_cnt;
      logic [mcast_pkg::NPORT-1:0] gport;
      mcast_pkg::sched_t sched;
      logic qon_prev;
      logic [15:0] sec_cnt;
      logic [25:0] tick_cnt;
      logic tick;
      logic resp_run;
      logic [7:0] resp_cnt;
      logic ovf;
      logic [5:0] gm_st;
      logic [6:0] gm_dy;
      logic gm_ok;
      logic qgo;
      mcast_pkg::gsq_t gsq;
      mcast_pkg::fwd_t fwd;
      logic [31:0] prdata;
      logic perr;
   } st_t;

   st_t s_r;
   st_t s_nxt;
   logic [mcast_pkg::NVLAN-1:0] qa;
   logic [mcast_pkg::NVLAN-1:0] qv;
   logic [7:0] fe;
   logic [7:0] fl;
   logic [7:0] fr;
   logic [7:0] gcnt;
   logic [mcast_pkg::NPORT-1:0] pbit;
   logic full;
   logic ev_eff;
   logic qon;
   logic qfire;
   logic resp_end;
   mcast_pkg::vcfg_t cv;
   mcast_pkg::qmode_t qm;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic snoop_eff(input mcast_pkg::vcfg_t c,
                                      input logic glob);
      return c.ipif ? c.vflag : (glob & c.vflag);
   endfunction

   function automatic mcast_pkg::qmode_t mode_eff(input mcast_pkg::vcfg_t c);
      return c.ipif ? c.ipqm : c.qmode;
   endfunction

   // returns {hit, index} of the entry for a VLAN and group
   function automatic logic [7:0] find(
      input mcast_pkg::grp_ent_t [mcast_pkg::NGRP-1:0] g,
      input logic [7:0] v,
      input logic [27:0] a);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < mcast_pkg::NGRP; i++) begin
         if (!r[7] && g[i].valid && g[i].vlan == v && g[i].group == a) begin
            r = {1'b1, 7'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] atleast1(input logic [15:0] x);
      return (x == 16'h0000) ? 16'h0001 : x;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.qgo = 1'b0;
      s_nxt.gsq.go = 1'b0;
      s_nxt.fwd.valid = 1'b0;
      s_nxt.gm_ok = 1'b0;
      s_nxt.tick = 1'b0;
      qa = '0;
      qv = '0;
      // querier role per VLAN
      for (int v = 0; v < mcast_pkg::NVLAN; v++) begin
         cv = s_r.vcfg[v];
         qm = mode_eff(cv);
         qa[v] = snoop_eff(cv, s_r.snoop) && qm != mcast_pkg::QM_NONE
                 && !s_r.vst[v].lost
                 && !(qm == mcast_pkg::QM_V2 && s_r.vst[v].v1seen);
         qv[v] = qa[v] && qm == mcast_pkg::QM_V2 && cv.ver2;
      end
      // occupancy and first free entry
      gcnt = 8'h00;
      fr = 8'h00;
      for (int i = 0; i < mcast_pkg::NGRP; i++) begin
         if (s_r.grp[i].valid) begin
            gcnt = gcnt + 8'h01;
         end else if (!fr[7]) begin
            fr = {1'b1, 7'(i)};
         end
      end
      full = !fr[7];
      // one-second tick
      if (s_r.tick_cnt == 26'(TICK_CYCLES - 1)) begin
         s_nxt.tick_cnt = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt + 26'h1;
      end
      // query schedule
      qon = s_r.snoop & s_r.qopt;
      s_nxt.qon_prev = qon;
      qfire = 1'b0;
      case (s_r.sched)
         mcast_pkg::SCH_IDLE: begin
            if (qon && !s_r.qon_prev) begin
               s_nxt.sched = mcast_pkg::SCH_FIRST;
               s_nxt.sec_cnt = mcast_pkg::FIRST_QUERY_S;
               s_nxt.tick_cnt = '0;
            end
         end
         mcast_pkg::SCH_FIRST, mcast_pkg::SCH_STARTUP,
         mcast_pkg::SCH_PERIODIC: begin
            if (s_r.tick) begin
               if (s_r.sec_cnt <= 16'h0001) begin
                  qfire = 1'b1;
                  if (s_r.sched == mcast_pkg::SCH_FIRST) begin
                     s_nxt.sched = mcast_pkg::SCH_STARTUP;
                     s_nxt.sec_cnt = atleast1(s_r.qint >> 2);
                  end else begin
                     s_nxt.sched = mcast_pkg::SCH_PERIODIC;
                     s_nxt.sec_cnt = atleast1(s_r.qint);
                  end
               end else begin
                  s_nxt.sec_cnt = s_r.sec_cnt - 16'h0001;
               end
            end
         end
         default: s_nxt.sched = mcast_pkg::SCH_IDLE;
      endcase
      if (!qon) begin
         s_nxt.sched = mcast_pkg::SCH_IDLE;
         qfire = 1'b0;
      end
      s_nxt.qgo = qfire;
      // response window after each general query
      resp_end = s_r.resp_run && s_r.tick && s_r.resp_cnt <= 8'h01;
      if (qfire) begin
         s_nxt.resp_run = 1'b1;
         s_nxt.resp_cnt = s_r.rlim;
      end else if (resp_end) begin
         s_nxt.resp_run = 1'b0;
      end else if (s_r.resp_run && s_r.tick) begin
         s_nxt.resp_cnt = s_r.resp_cnt - 8'h01;
      end
      for (int i = 0; i < mcast_pkg::NGRP; i++) begin
         if (s_r.tick && s_r.grp[i].lcnt != 2'h0) begin
            s_nxt.grp[i].lcnt = s_r.grp[i].lcnt - 2'h1;
            if (s_r.grp[i].lcnt == 2'h1) begin
               s_nxt.grp[i].members = s_r.grp[i].members
                                      & ~s_r.grp[i].leave;
               s_nxt.grp[i].leave = '0;
            end
         end
         if (resp_end) begin
            s_nxt.grp[i].members = s_nxt.grp[i].members
                                   & ~s_r.grp[i].unconf;
            s_nxt.grp[i].unconf = '0;
         end
         if (qfire) begin
            s_nxt.grp[i].unconf = s_r.grp[i].members;
         end
      end
      // apb: read data and error caught in the setup phase
      if (psel && !penable) begin
         s_nxt.perr = 1'b0;
         case (paddr)
            mcast_pkg::CTRL_OFS:
               s_nxt.prdata = {29'h0, s_r.gmrp, s_r.qopt, s_r.snoop};
            mcast_pkg::QINT_OFS: s_nxt.prdata = {16'h0, s_r.qint};
            mcast_pkg::RLIM_OFS: s_nxt.prdata = {24'h0, s_r.rlim};
            mcast_pkg::VIDX_OFS: s_nxt.prdata = {24'h0, s_r.vidx};
            mcast_pkg::VCFG_OFS:
               s_nxt.prdata = {25'h0, s_r.vcfg[s_r.vidx]};
            mcast_pkg::GPORT_OFS: s_nxt.prdata = {6'h0, s_r.gport};
            mcast_pkg::STAT_OFS:
               s_nxt.prdata = {s_r.gm_dy, s_r.gm_st, s_r.admit_cnt,
                               s_r.sched, s_r.ovf, gcnt};
            default: begin
               s_nxt.prdata = 32'h0000_0000;
               s_nxt.perr = 1'b1;
            end
         endcase
      end
      if (psel && penable && pwrite && !s_r.perr) begin
         case (paddr)
            mcast_pkg::CTRL_OFS: begin
               s_nxt.snoop = pwdata[mcast_pkg::CTRL_SNOOP];
               s_nxt.qopt = pwdata[mcast_pkg::CTRL_QOPT];
               s_nxt.gmrp = pwdata[mcast_pkg::CTRL_GMRP];
            end
            mcast_pkg::QINT_OFS: s_nxt.qint = pwdata[15:0];
            mcast_pkg::RLIM_OFS: s_nxt.rlim = pwdata[7:0];
            mcast_pkg::VIDX_OFS: s_nxt.vidx = pwdata[7:0];
            mcast_pkg::VCFG_OFS: begin
               s_nxt.vcfg[s_r.vidx] = mcast_pkg::vcfg_t'(pwdata[6:0]);
               // new settings restart querier election
               s_nxt.vst[s_r.vidx].v1seen = 1'b0;
               s_nxt.vst[s_r.vidx].lost = 1'b0;
            end
            mcast_pkg::GPORT_OFS: s_nxt.gport = pwdata[mcast_pkg::NPORT-1:0];
            mcast_pkg::STAT_OFS: begin
               if (pwdata[mcast_pkg::STAT_OVF]) begin
                  s_nxt.ovf = 1'b0;
               end
            end
            default: s_nxt.ovf = s_nxt.ovf;
         endcase
      end
      // igmp events, after the clears so that a set wins
      cv = s_r.vcfg[ev.vlan];
      ev_eff = snoop_eff(cv, s_r.snoop);
      fe = find(s_r.grp, ev.vlan, ev.group);
      pbit = '0;
      pbit[ev.port] = 1'b1;
      if (ev.query) begin
         if (ev.v1) begin
            s_nxt.vst[ev.vlan].v1seen = 1'b1;
         end
         if (ev.lower) begin
            s_nxt.vst[ev.vlan].lost = 1'b1;
         end
      end
      if (ev.report && ev_eff) begin
         if (s_r.vst[ev.vlan].admit || s_r.admit_cnt < mcast_pkg::VLAN_ADMIT_MAX)
         begin
            if (!s_r.vst[ev.vlan].admit) begin
               s_nxt.vst[ev.vlan].admit = 1'b1;
               s_nxt.admit_cnt = s_r.admit_cnt + 8'h01;
            end
            if (fe[7]) begin
               s_nxt.grp[fe[6:0]].members = s_nxt.grp[fe[6:0]].members | pbit;
               s_nxt.grp[fe[6:0]].unconf = s_nxt.grp[fe[6:0]].unconf & ~pbit;
               s_nxt.grp[fe[6:0]].leave = s_nxt.grp[fe[6:0]].leave & ~pbit;
            end else if (!full) begin
               s_nxt.grp[fr[6:0]] = '0;
               s_nxt.grp[fr[6:0]].valid = 1'b1;
               s_nxt.grp[fr[6:0]].vlan = ev.vlan;
               s_nxt.grp[fr[6:0]].group = ev.group;
               s_nxt.grp[fr[6:0]].members = pbit;
            end else begin
               s_nxt.ovf = 1'b1;
            end
         end
      end
      // v1 mode and v1 version ignore leaves
      if (ev.leave && ev_eff && qv[ev.vlan] && fe[7]) begin
         s_nxt.gsq.go = 1'b1;
         s_nxt.gsq.vlan = ev.vlan;
         s_nxt.gsq.group = ev.group;
         s_nxt.grp[fe[6:0]].leave = s_nxt.grp[fe[6:0]].leave
                                    | (pbit & s_r.grp[fe[6:0]].members);
         s_nxt.grp[fe[6:0]].lcnt = mcast_pkg::LEAVE_TICKS;
      end
      for (int i = 0; i < mcast_pkg::NGRP; i++) begin
         if (s_nxt.grp[i].valid && s_nxt.grp[i].members == '0) begin
            s_nxt.grp[i] = '0;
         end
      end
      // forwarding lookup
      fl = find(s_r.grp, lk.vlan, lk.group);
      if (lk.valid) begin
         s_nxt.fwd.valid = 1'b1;
         s_nxt.fwd.flood = !snoop_eff(s_r.vcfg[lk.vlan], s_r.snoop)
                           || !s_r.vst[lk.vlan].admit
                           || (!fl[7] && full);
         s_nxt.fwd.mask = fl[7] ? s_r.grp[fl[6:0]].members : '0;
      end
      // gmrp entry accounting
      if (s_r.gmrp && gm.add) begin
         if (gm.is_static && s_r.gm_st < mcast_pkg::GMRP_STATIC_MAX) begin
            s_nxt.gm_st = s_r.gm_st + 6'h01;
            s_nxt.gm_ok = 1'b1;
         end else if (!gm.is_static && s_r.gm_dy < mcast_pkg::GMRP_DYN_MAX)
         begin
            s_nxt.gm_dy = s_r.gm_dy + 7'h01;
            s_nxt.gm_ok = 1'b1;
         end
      end else if (s_r.gmrp && gm.del) begin
         if (gm.is_static && s_r.gm_st != 6'h00) begin
            s_nxt.gm_st = s_r.gm_st - 6'h01;
         end else if (!gm.is_static && s_r.gm_dy != 7'h00) begin
            s_nxt.gm_dy = s_r.gm_dy - 7'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.vcfg <= {mcast_pkg::NVLAN{mcast_pkg::VCFG_RST}};
         s_r.qint <= mcast_pkg::QINT_RST;
         s_r.rlim <= mcast_pkg::RLIM_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = psel & penable;
   assign pslverr = psel & penable & s_r.perr;
   assign query_go = s_r.qgo;
   assign querier_act = qa;
   assign querier_ver2 = qv;
   assign gsq = s_r.gsq;
   assign fwd = s_r.fwd;
   assign gmrp_port_en = s_r.gmrp ? s_r.gport : '0;
   assign gmrp_ok = s_r.gm_ok;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [15:0] tq_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tq_r <= 16'h0000;
      end else if (s_r.qgo || s_r.sched == mcast_pkg::SCH_IDLE) begin
         tq_r <= 16'h0000;
      end else if (s_r.tick) begin
         tq_r <= tq_r + 16'h0001;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_leave_v2;
      ev.leave && snoop_eff(s_r.vcfg[ev.vlan], s_r.snoop)
      && qv[ev.vlan] && find(s_r.grp, ev.vlan, ev.group) != 8'h00;
   endsequence
   property p_leave_query;
      s_leave_v2 |=> gsq.go && gsq.vlan == $past(ev.vlan);
   endproperty
   a_leave_query: assert property (p_leave_query)
      else $error("leave did not raise a group query");
   property p_v1_no_leave;
      ev.leave && !qv[ev.vlan] |=> !gsq.go;
   endproperty
   a_v1_no_leave: assert property (p_v1_no_leave)
      else $error("leave handled outside v2 querier");
   property p_v1_silence;
      ev.query && ev.v1 && mode_eff(s_r.vcfg[ev.vlan]) == mcast_pkg::QM_V2
      |=> !querier_act[$past(ev.vlan)];
   endproperty
   a_v1_silence: assert property (p_v1_silence)
      else $error("v2 querier active beside a v1 querier");
   property p_first_hold;
      $rose(s_r.sched == mcast_pkg::SCH_FIRST)
      |-> s_r.sec_cnt == mcast_pkg::FIRST_QUERY_S && s_r.tick_cnt == '0;
   endproperty
   a_first_hold: assert property (p_first_hold)
      else $error("first query delay not loaded");
   sequence s_startup_query;
      query_go && s_r.sched == mcast_pkg::SCH_PERIODIC
      && $past(s_r.sched) == mcast_pkg::SCH_STARTUP;
   endsequence
   property p_second_query;
      s_startup_query |-> tq_r == atleast1(s_r.qint >> 2);
   endproperty
   a_second_query: assert property (p_second_query)
      else $error("second query not a quarter interval later");
   property p_periodic;
      query_go && $past(s_r.sched) == mcast_pkg::SCH_PERIODIC
      |-> tq_r == atleast1(s_r.qint);
   endproperty
   a_periodic: assert property (p_periodic)
      else $error("periodic query off interval");
   property p_no_snoop_flood;
      lk.valid && !snoop_eff(s_r.vcfg[lk.vlan], s_r.snoop)
      |=> fwd.valid && fwd.flood;
   endproperty
   a_no_snoop_flood: assert property (p_no_snoop_flood)
      else $error("unsnooped VLAN not flooded");
   property p_full_flood;
      lk.valid && full && find(s_r.grp, lk.vlan, lk.group) == 8'h00
      |=> fwd.flood;
   endproperty
   a_full_flood: assert property (p_full_flood)
      else $error("new group not flooded with full table");
   property p_admit_cap;
      s_r.admit_cnt <= mcast_pkg::VLAN_ADMIT_MAX;
   endproperty
   a_admit_cap: assert property (p_admit_cap)
      else $error("too many VLANs admitted");
   property p_gmrp_off;
      gm.add && !s_r.gmrp |=> !gmrp_ok && gmrp_port_en == '0;
   endproperty
   a_gmrp_off: assert property (p_gmrp_off)
      else $error("gmrp acted while off");
   property p_gmrp_cap;
      s_r.gm_st <= mcast_pkg::GMRP_STATIC_MAX
      && s_r.gm_dy <= mcast_pkg::GMRP_DYN_MAX;
   endproperty
   a_gmrp_cap: assert property (p_gmrp_cap)
      else $error("gmrp entry limit passed");
   property p_resp_drop;
      $fell(s_r.resp_run) |-> s_r.grp[0].unconf == '0;
   endproperty
   a_resp_drop: assert property (p_resp_drop)
      else $error("unanswered members kept after window");
   property p_tick;
      s_r.tick |-> $past(s_r.tick_cnt) == 26'(TICK_CYCLES - 1);
   endproperty
   a_tick: assert property (p_tick)
      else $error("second tick off period");
endmodule

// >>> tb/host_model.sv
// behavioural hosts and routers that feed parsed igmp events
module host_model (
   // clock
   input wire logic pclk,
   // parsed events toward the tracker
   output mcast_pkg::igmp_ev_t ev
);
   timeunit 1ns;
   timeprecision 1ps;
   initial ev = '0;
   // one-cycle pulse, then the released fields are scrambled
   // kind k is {lower, v1, query, report, leave}
   task automatic send(input logic [4:0] k, input logic [7:0] v,
                       input logic [27:0] g, input logic [4:0] p);
      @(posedge pclk);
      ev <= '{query: k[2], report: k[1], leave: k[0], v1: k[3],
              lower: k[4], vlan: v, group: g, port: p};
      @(posedge pclk);
      ev <= '{query: 1'b0, report: 1'b0, leave: 1'b0, v1: 1'b0,
              lower: 1'b0, vlan: ~v, group: ~g, port: ~p};
   endtask
endmodule

// >>> tb/igmp_snoop_querier_test.sv
// self-checking bench for the multicast group tracker
module igmp_snoop_querier_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, query_go, gmrp_ok;
   logic [255:0] qa, qv2;
   logic [25:0] gpe;
   logic [15:0] lf = 16'h23BD;
   logic [27:0] g;
   logic [4:0] p;
   mcast_pkg::igmp_ev_t ev;
   mcast_pkg::lookup_t lk = '0;
   mcast_pkg::gmrp_req_t gm = '0;
   mcast_pkg::gsq_t gsq;
   mcast_pkg::fwd_t fwd;
   int mismatches = 0, checked = 0, cyc = 0, t0, nok;
   always #10 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   host_model host (.pclk(pclk), .ev(ev));
   igmp_snoop_querier #(.TICK_CYCLES(TK)) dut (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ev(ev), .lk(lk), .gm(gm), .query_go(query_go),
      .querier_act(qa), .querier_ver2(qv2), .gsq(gsq), .fwd(fwd),
      .gmrp_port_en(gpe), .gmrp_ok(gmrp_ok));
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic look(input logic [7:0] v, input logic [27:0] a);
      @(posedge pclk);
      lk <= '{valid: 1'b1, vlan: v, group: a};
      @(posedge pclk);
      lk <= '{valid: 1'b0, vlan: ~v, group: ~a};
      #1;
   endtask
   // n gmrp adds back to back, counting the accepted ones
   task automatic gmadd(input logic st, input int n, output int ok);
      ok = 0;
      for (int j = 0; j <= n; j++) begin
         @(posedge pclk);
         gm <= '{add: 1'(j < n), del: 1'b0, is_static: st};
         #1 ok += int'(gmrp_ok);
      end
   endtask
   task automatic gap(input int n);
      while (query_go !== 1'b1 && cyc - t0 < 300 * TK) @(negedge pclk);
      chk("query gap", 32'((cyc - t0 + TK / 2) / TK), 32'(n));
      t0 = cyc;
      @(negedge pclk);
   endtask
   task automatic end_of_test;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      mismatches++;
      end_of_test;
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, mcast_pkg::QINT_OFS, 0); chk("qint", rd, 32'h7D);
      apb(0, mcast_pkg::CTRL_OFS, 0); chk("ctrl", rd, 32'h0);
      apb(0, mcast_pkg::VCFG_OFS, 0); chk("vcfg", rd, 32'h9);
      apb(0, 8'h40, 0); chk("unmapped", {31'h0, err}, 32'h1);
      lf = nxt(lf);
      g = {12'hE00, lf};
      p = 5'(lf % 26);
      look(1, g);
      chk("flood off", {30'h0, fwd.valid, fwd.flood}, 32'h3);
      apb(1, mcast_pkg::VIDX_OFS, 1);
      apb(1, mcast_pkg::VCFG_OFS, 32'h0D);
      apb(1, mcast_pkg::CTRL_OFS, 3);
      t0 = cyc;
      chk("v2 act", {30'h0, qa[1], qv2[1]}, 32'h3);
      chk("none act", {31'h0, qa[2]}, 32'h0);
      host.send(5'b00010, 1, g, p);
      look(1, g); chk("mask", {6'h0, fwd.mask}, 32'h1 << p);
      chk("filter", {31'h0, fwd.flood}, 32'h0);
      host.send(5'b00001, 1, g, p);
      #1 chk("gsq", {3'h0, gsq.go, gsq.group}, {4'h1, g});
      chk("gsq vlan", {24'h0, gsq.vlan}, 32'h1);
      repeat (3 * TK) @(posedge pclk);
      look(1, g); chk("left", {6'h0, fwd.mask}, 32'h0);
      host.send(5'b01100, 1, g, p);
      #1 chk("v1 silence", {31'h0, qa[1]}, 32'h0);
      for (int i = 0; i < 129; i++) begin
         lf = nxt(lf);
         host.send(5'b00010, 1, 28'h100 + 28'(i), 5'(lf % 26));
         if (i == 127) begin
            apb(0, mcast_pkg::STAT_OFS, 0);
            chk("full", rd[8:0], 32'h80);
         end
      end
      look(1, 28'h1FF); chk("ovf", {31'h0, fwd.flood}, 32'h1);
      apb(0, mcast_pkg::STAT_OFS, 0);
      chk("ovf bit", rd[8:0], 32'h180);
      host.send(5'b00001, 1, 28'h100, p);
      #1 chk("v1 leave", {31'h0, gsq.go}, 32'h0);
      apb(1, mcast_pkg::VIDX_OFS, 3);
      apb(1, mcast_pkg::VCFG_OFS, 32'h03);
      chk("v1 act", {30'h0, qa[3], qv2[3]}, 32'h2);
      host.send(5'b10100, 3, g, p);
      #1 chk("lost", {31'h0, qa[3]}, 32'h0);
      apb(1, mcast_pkg::VIDX_OFS, 4);
      apb(1, mcast_pkg::VCFG_OFS, 32'h59);
      chk("override", {30'h0, qa[4], qv2[4]}, 32'h3);
      apb(1, mcast_pkg::GPORT_OFS, {16'h0, lf});
      chk("gmrp off", {6'h0, gpe}, 32'h0);
      gmadd(1'b1, 1, nok); chk("gmrp idle", 32'(nok), 32'h0);
      apb(1, mcast_pkg::CTRL_OFS, 7);
      #20 chk("gmrp on", {6'h0, gpe}, {16'h0, lf});
      gmadd(1'b1, 33, nok); chk("static", 32'(nok), 32'h20);
      gmadd(1'b0, 65, nok); chk("dynamic", 32'(nok), 32'h40);
      apb(0, mcast_pkg::STAT_OFS, 0);
      chk("gmrp cnt", {19'h0, rd[31:19]}, {19'h0, 7'h40, 6'h20});
      gap(255);
      host.send(5'b00010, 1, 28'h101, p);
      repeat (11 * TK) @(posedge pclk);
      look(1, 28'h100);
      chk("dropped", {30'h0, fwd.flood, |fwd.mask}, 32'h0);
      look(1, 28'h101); chk("kept", {6'h0, fwd.mask}, 32'h1 << p);
      gap(31);
      gap(125);
      end_of_test;
   end
endmodule
